// *** cls_clkdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
// Divider making the active serial clock; idles low
module cls_clkdiv (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [3:0] halfCycles,
    output logic clkOut,
    output logic fallNext
);
    logic [3:0] cnt;
    logic wrap;

    assign wrap = (cnt == halfCycles - 4'h1);
    // Edge the shifter acts on coincides with the pin falling
    assign fallNext = run && wrap && clkOut;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            clkOut <= 1'b0;
        end else if (!run) begin
            cnt <= 4'h0;
            clkOut <= 1'b0;
        end else if (wrap) begin
            cnt <= 4'h0;
            clkOut <= !clkOut;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// *** cls_config_load_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - User mode: lines high; request low restarts
// - Status low, done low within 600 ns
// - Status low between 268 and 1506 us
// - Status released within 1506 us after request
// - Status low through power-on delay
// - Done low from power-up through loading
// - Done high only after whole bitstream arrives
// - Init-done pin low until initialization ends
// - Passive modes capture on configuration clock rise
// - Active serial: drive and sample on falling edges
// - Active serial x4 takes four bits per clock
// - Active serial clock from oscillator, four maxima
// - Initialization counts 8576 cycles of chosen clock
// - Oscillator init: user mode 175 to 437 us
// - User clock enabled, then 8576 user cycles
// - Clock-to-data ratio 1, 2, 4 or 8
module cls_config_load_sequencer #(
    parameter cls_pkg::cls_timer_type POR_CYCLES = cls_pkg::cls_timer_type'(cls_pkg::STATUS_MIN_CYCLES),
    parameter cls_pkg::cls_timer_type STATUS_MIN_CYCLES = cls_pkg::cls_timer_type'(cls_pkg::STATUS_MIN_CYCLES),
    parameter cls_pkg::cls_timer_type INIT_OSC_CYCLES = cls_pkg::cls_timer_type'(cls_pkg::UM_MIN_CYCLES),
    parameter cls_pkg::cls_timer_type INIT_CLOCK_CYCLES = cls_pkg::cls_timer_type'(cls_pkg::INIT_CLOCK_CYCLES)
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic config_request_n,
    input wire logic cfg_state_n_in,
    output logic cfg_state_n_out,
    output logic cfg_state_n_oe,
    output logic load_complete,
    input wire logic cfg_clock_in,
    output logic cfg_clock_out,
    output logic cfg_clock_oe,
    input wire logic [31:0] cfgData,
    output logic flash_io0,
    output logic flash_io0_oe,
    input wire logic [3:0] flash_io_bus,
    output logic flashSelect_n,
    input wire logic user_init_clock,
    output logic initDone_n,
    output logic initDoneOe,
    output logic userMode
);
    // ----------------------------------------------------------------
    // Pin synchronisers and edge finders
    // ----------------------------------------------------------------
    logic reqS, stateS, cfgClkS, userClkS, cfgClkQ, userClkQ;
    logic [31:0] dataS;
    logic [3:0] busS;
    logic cfgRise, cfgFall, userRise;

    cls_sync #(.WIDTH(40), .RESET_VAL({2'h3, 38'h00_0000_0000})) pinSync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async({config_request_n, cfg_state_n_in, cfg_clock_in, user_init_clock, cfgData, flash_io_bus}),
        .synced({reqS, stateS, cfgClkS, userClkS, dataS, busS})
    );

    // Data goes through the same depth as the clock, keeping alignment
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgClkQ <= 1'b0;
            userClkQ <= 1'b0;
        end else begin
            cfgClkQ <= cfgClkS;
            userClkQ <= userClkS;
        end
    end
    assign cfgRise = cfgClkS && !cfgClkQ;
    assign cfgFall = !cfgClkS && cfgClkQ;
    assign userRise = userClkS && !userClkQ;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [11:0] ctrl;
    logic [31:0] cfgLength, unitCount, lastData;
    cls_pkg::cls_state_type state, next_state;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= cls_pkg::CTRL_RESET;
            cfgLength <= cls_pkg::LENGTH_RESET;
        end else if (regWrite) begin
            if (regAddr == cls_pkg::ADDR_CTRL) ctrl <= regWdata[11:0];
            if (regAddr == cls_pkg::ADDR_LENGTH) cfgLength <= regWdata;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 32'h0000_0000;
        end else if (regRead) begin
            case (regAddr)
                cls_pkg::ADDR_CTRL: regRdata <= {20'h0_0000, ctrl};
                cls_pkg::ADDR_LENGTH: regRdata <= cfgLength;
                cls_pkg::ADDR_STATUS: regRdata <= {25'h000_0000, reqS, stateS, userMode, load_complete, state};
                cls_pkg::ADDR_COUNT: regRdata <= unitCount;
                cls_pkg::ADDR_DATA: regRdata <= lastData;
                default: regRdata <= 32'h0000_0000;
            endcase
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Control decode
    // ----------------------------------------------------------------
    logic [1:0] mode, width, ratioSel, initSel, speedSel;
    logic asMode, initEn, countReached;
    logic [3:0] asHalf;
    logic [2:0] ratioLast;

    assign mode = ctrl[cls_pkg::CTRL_MODE +: 2];
    assign width = ctrl[cls_pkg::CTRL_WIDTH +: 2];
    assign ratioSel = ctrl[cls_pkg::CTRL_RATIO +: 2];
    assign speedSel = ctrl[cls_pkg::CTRL_SPEED +: 2];
    assign initEn = ctrl[cls_pkg::CTRL_INITEN];
    assign asMode = (mode == cls_pkg::MODE_AS);
    // Configuration clock cannot time initialization in active serial
    assign initSel = (asMode && ctrl[cls_pkg::CTRL_INIT +: 2] == cls_pkg::INIT_CFG) ?
                     cls_pkg::INIT_OSC : ctrl[cls_pkg::CTRL_INIT +: 2];
    // Ratio applies to parallel mode only; serial is always one
    assign ratioLast = (mode == cls_pkg::MODE_FPP) ? 3'((4'h1 << ratioSel) - 4'h1) : 3'h0;
    assign countReached = (unitCount >= cfgLength);

    // Fastest setting refused for chains; falls back one step
    always_comb begin
        case ((speedSel == 2'h3 && ctrl[cls_pkg::CTRL_CHAIN]) ? 2'h2 : speedSel)
            2'h0: asHalf = cls_pkg::as_half(cls_pkg::AS_F0_KHZ);
            2'h1: asHalf = cls_pkg::as_half(cls_pkg::AS_F1_KHZ);
            2'h2: asHalf = cls_pkg::as_half(cls_pkg::AS_F2_KHZ);
            default: asHalf = cls_pkg::as_half(cls_pkg::AS_F3_KHZ);
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    cls_pkg::cls_timer_type lowTimer, initCnt;
    logic [1:0] tailFalls, cuWait;
    logic initTick, initEnd;

    assign initEnd = (initSel == cls_pkg::INIT_OSC) ? (initCnt == INIT_OSC_CYCLES) : (initCnt == INIT_CLOCK_CYCLES);

    always_comb begin
        next_state = state;
        case (state)
            cls_pkg::ST_POR: if (lowTimer >= POR_CYCLES) next_state = cls_pkg::ST_RELEASE;
            cls_pkg::ST_RESET: if (reqS && lowTimer >= STATUS_MIN_CYCLES) next_state = cls_pkg::ST_RELEASE;
            cls_pkg::ST_RELEASE: if (stateS) next_state = cls_pkg::ST_LOAD;
            cls_pkg::ST_LOAD: if (countReached) next_state = asMode ? cls_pkg::ST_INIT : cls_pkg::ST_TAIL;
            cls_pkg::ST_TAIL: if (tailFalls == 2'h2) next_state = cls_pkg::ST_INIT;
            cls_pkg::ST_INIT: if (initEnd) next_state = cls_pkg::ST_USER;
            cls_pkg::ST_USER: next_state = cls_pkg::ST_USER;
            default: next_state = cls_pkg::ST_POR;
        endcase
        // A low request wins from any state
        if (!reqS) next_state = cls_pkg::ST_RESET;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) state <= cls_pkg::ST_POR;
        else state <= next_state;
    end

    // Status low time, restarted on each entry to reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) lowTimer <= '0;
        else if (next_state != state) lowTimer <= '0;
        else if (lowTimer != '1) lowTimer <= lowTimer + 1'b1;
    end

    // Two falls after done start initialization
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) tailFalls <= 2'h0;
        else if (state != cls_pkg::ST_TAIL) tailFalls <= 2'h0;
        else if (cfgFall) tailFalls <= tailFalls + 2'h1;
    end

    // Initialization clock: oscillator, user pin after a short wait, or link clock
    assign initTick = (initSel == cls_pkg::INIT_OSC) ? 1'b1 :
                      (initSel == cls_pkg::INIT_USER) ? (cuWait == 2'(cls_pkg::CU_CYCLES) && userRise) : cfgRise;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            initCnt <= '0;
            cuWait <= 2'h0;
        end else if (state != cls_pkg::ST_INIT) begin
            initCnt <= '0;
            cuWait <= 2'h0;
        end else begin
            if (cuWait != 2'(cls_pkg::CU_CYCLES)) cuWait <= cuWait + 2'h1;
            if (initTick && !initEnd) initCnt <= initCnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Passive capture and active serial loading
    // ----------------------------------------------------------------
    logic [2:0] ratioPhase;
    logic [5:0] asCmdCnt;
    logic asRun, asFall;

    assign asRun = asMode && state == cls_pkg::ST_LOAD && !countReached;

    cls_clkdiv asClock (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(asRun),
        .halfCycles(asHalf),
        .clkOut(cfg_clock_out),
        .fallNext(asFall)
    );

    // Only the first rising edge of each ratio group takes a word
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unitCount <= 32'h0000_0000;
            lastData <= 32'h0000_0000;
            ratioPhase <= 3'h0;
            asCmdCnt <= 6'h00;
            flash_io0 <= 1'b1;
        end else if (state != cls_pkg::ST_LOAD) begin
            if (state != cls_pkg::ST_USER && state != cls_pkg::ST_INIT && state != cls_pkg::ST_TAIL) begin
                unitCount <= 32'h0000_0000;
            end
            ratioPhase <= 3'h0;
            asCmdCnt <= 6'h01;
            flash_io0 <= cls_pkg::AS_READ_CMD[31];
        end else if (asMode) begin
            if (asFall) begin
                if (asCmdCnt < 6'(cls_pkg::AS_CMD_BITS)) begin
                    flash_io0 <= cls_pkg::AS_READ_CMD[5'(6'd31 - asCmdCnt)];
                    asCmdCnt <= asCmdCnt + 6'h01;
                end else if (asCmdCnt == 6'(cls_pkg::AS_CMD_BITS)) begin
                    asCmdCnt <= asCmdCnt + 6'h01;
                end else begin
                    // Flash data sampled on the same falling edge
                    lastData <= (width == 2'h1) ? {lastData[27:0], busS} : {lastData[30:0], busS[1]};
                    unitCount <= unitCount + 32'h0000_0001;
                end
            end
        end else if (cfgRise && !countReached) begin
            ratioPhase <= (ratioPhase == ratioLast) ? 3'h0 : ratioPhase + 3'h1;
            if (ratioPhase == 3'h0) begin
                unitCount <= unitCount + 32'h0000_0001;
                if (mode == cls_pkg::MODE_PS) lastData <= {lastData[30:0], dataS[0]};
                else if (width == 2'h0) lastData <= {24'h00_0000, dataS[7:0]};
                else if (width == 2'h1) lastData <= {16'h0000, dataS[15:0]};
                else lastData <= dataS;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers, all registered; status and init-done outputs tied low, enables and flags from the next state
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_state_n_out <= 1'b0;
            cfg_state_n_oe <= 1'b1;
            load_complete <= 1'b0;
            userMode <= 1'b0;
            cfg_clock_oe <= 1'b0;
            flash_io0_oe <= 1'b0;
            flashSelect_n <= 1'b1;
            initDone_n <= 1'b0;
            initDoneOe <= 1'b0;
        end else begin
            cfg_state_n_out <= 1'b0;
            cfg_state_n_oe <= (next_state == cls_pkg::ST_POR || next_state == cls_pkg::ST_RESET);
            load_complete <= (next_state == cls_pkg::ST_TAIL || next_state == cls_pkg::ST_INIT ||
                              next_state == cls_pkg::ST_USER);
            userMode <= (next_state == cls_pkg::ST_USER);
            cfg_clock_oe <= asMode && next_state == cls_pkg::ST_LOAD;
            flash_io0_oe <= asMode && next_state == cls_pkg::ST_LOAD;
            flashSelect_n <= !(asMode && next_state == cls_pkg::ST_LOAD);
            initDone_n <= 1'b0;
            initDoneOe <= initEn && (next_state == cls_pkg::ST_LOAD || next_state == cls_pkg::ST_TAIL ||
                                     next_state == cls_pkg::ST_INIT);
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    cls_pkg::cls_timer_type lowCnt, relCnt, initElapsed;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt <= '0;
            relCnt <= '0;
            initElapsed <= '0;
        end else begin
            lowCnt <= cfg_state_n_oe ? lowCnt + 1'b1 : '0;
            relCnt <= (state == cls_pkg::ST_RESET && reqS) ? relCnt + 1'b1 : '0;
            initElapsed <= (state == cls_pkg::ST_INIT) ? initElapsed + 1'b1 : '0;
        end
    end

    a_req_to_status: assert property ($fell(reqS) |=> cfg_state_n_oe && !load_complete && !userMode)
        else $error("status or done not pulled low after request");
    a_status_min: assert property ($fell(cfg_state_n_oe) && $past(state) == cls_pkg::ST_RESET
                                   |-> lowCnt >= STATUS_MIN_CYCLES)
        else $error("status released too early");
    a_release_max: assert property (relCnt <= cls_pkg::cls_timer_type'(cls_pkg::STATUS_MAX_CYCLES))
        else $error("status held too long after request high");
    a_done_in_load: assert property (state inside {cls_pkg::ST_POR, cls_pkg::ST_RESET, cls_pkg::ST_RELEASE}
                                     |=> !load_complete)
        else $error("done high before loading finished");
    a_done_count: assert property ($rose(load_complete) |-> unitCount >= cfgLength ##1 load_complete)
        else $error("done high without full bitstream");
    a_as_fall_drive: assert property ($changed(flash_io0) && state == cls_pkg::ST_LOAD
                                      |-> $fell(cfg_clock_out))
        else $error("flash output changed off a falling edge");
    a_passive_rise: assert property (!asMode && state == cls_pkg::ST_LOAD && $past(state) == cls_pkg::ST_LOAD
                                     && $changed(unitCount) |-> $past(cfgRise))
        else $error("word taken without a clock rise");
    a_osc_init_time: assert property ($rose(userMode) && $past(initSel) == cls_pkg::INIT_OSC
                                      |-> initElapsed > INIT_OSC_CYCLES &&
                                      initElapsed <= cls_pkg::cls_timer_type'(cls_pkg::UM_MAX_CYCLES))
        else $error("oscillator initialization time out of range");
    a_init_pin: assert property (state == cls_pkg::ST_INIT && $past(state) == cls_pkg::ST_INIT && initEn
                                 && $past(initEn) |-> initDoneOe)
        else $error("init-done pin not held low");
    a_user_hold: assert property (state == cls_pkg::ST_USER && reqS
                                  |=> state == cls_pkg::ST_USER && $stable(unitCount))
        else $error("user mode disturbed by clock activity");

    c_user_mode: cover property ($rose(userMode));
    c_as_done: cover property (asMode && $rose(load_complete));
    c_restart: cover property (state == cls_pkg::ST_USER ##1 state == cls_pkg::ST_RESET);
endmodule
`default_nettype wire

// *** cls_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Passive host
// ----------------------------------------------------------------
// Clock parks low outside frames; data is inverted after each serial send
module cls_host_model (
    input wire logic statusN,
    output logic requestN,
    output logic cfgClk,
    output logic [31:0] cfgData
);
    initial begin
        requestN = 1'b1;
        cfgClk = 1'b0;
        cfgData = 32'h0000_0000;
    end
    // Request pulse, then wait on the status wire before clocking
    task automatic reconfig();
        #3;
        requestN = 1'b0;
        #2000;
        requestN = 1'b1;
        wait (statusN === 1'b1);
        #2000;
    endtask
    // Stream MSB first on bit 0 at 200 ns, well under the limit
    task automatic send(input int n, input logic [31:0] w);
        #3;
        for (int i = n - 1; i >= 0; i--) begin
            cfgData[0] = w[i];
            #100 cfgClk = 1'b1;
            #100 cfgClk = 1'b0;
        end
        cfgData = ~cfgData;
    endtask
    // Trailing pulses that start initialization
    task automatic pulses(input int n);
        #3;
        repeat (n) begin
            #100 cfgClk = 1'b1;
            #100 cfgClk = 1'b0;
        end
    endtask
    // Parallel words, each held for a whole ratio group of clocks
    task automatic sendWords(input int n, input int ratio, input logic [31:0] w);
        #3;
        repeat (n) begin
            cfgData = w;
            // Last group also gives the spare cycles past the final word
            repeat (ratio) begin
                #100 cfgClk = 1'b1;
                #100 cfgClk = 1'b0;
            end
            w = w + 32'h0000_0001;
        end
    endtask
endmodule
`default_nettype wire

// *** cls_pkg.sv ***
// ----------------------------------------------------------------
// Configuration load sequencer constants
// ----------------------------------------------------------------
package cls_pkg;
    // Core clock
    localparam int CORE_MHZ = 40;
    localparam int CORE_KHZ = CORE_MHZ * 1000;
    localparam int TIMER_W = 17;
    typedef logic [TIMER_W-1:0] cls_timer_type;

    // Pin timing, times as printed, cycles derived
    localparam int T_REQ2STAT_NS = 600;
    localparam int REQ2STAT_CYCLES = T_REQ2STAT_NS * CORE_MHZ / 1000;
    localparam int T_STATUS_MIN_US = 268;
    localparam int STATUS_MIN_CYCLES = T_STATUS_MIN_US * CORE_MHZ;
    localparam int T_STATUS_MAX_US = 1506;
    localparam int STATUS_MAX_CYCLES = T_STATUS_MAX_US * CORE_MHZ;
    localparam int T_CD2UM_MIN_US = 175;
    localparam int UM_MIN_CYCLES = T_CD2UM_MIN_US * CORE_MHZ;
    localparam int T_CD2UM_MAX_US = 437;
    localparam int UM_MAX_CYCLES = T_CD2UM_MAX_US * CORE_MHZ;
    localparam int INIT_CLOCK_CYCLES = 8576;
    localparam int CFG_FMAX_MHZ = 125;
    localparam int T_CD2CU_NS = 4 * 1000 / CFG_FMAX_MHZ;
    localparam int CU_CYCLES = (T_CD2CU_NS * CORE_MHZ + 999) / 1000;

    // Active serial clock maxima and half periods
    localparam int AS_F0_KHZ = 12500;
    localparam int AS_F1_KHZ = 25000;
    localparam int AS_F2_KHZ = 50000;
    localparam int AS_F3_KHZ = 100000;
    localparam int AS_HALF_MIN = 2;
    function automatic logic [3:0] as_half(input int fKhz);
        int h;
        h = (CORE_KHZ + 2 * fKhz - 1) / (2 * fKhz);
        return 4'((h < AS_HALF_MIN) ? AS_HALF_MIN : h);
    endfunction
    localparam int AS_CMD_BITS = 32;
    localparam logic [31:0] AS_READ_CMD = 32'h0300_0000;

    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LENGTH = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam logic [31:0] LENGTH_RESET = 32'h0000_0000;

    // Control fields
    localparam int CTRL_MODE = 0;
    localparam int CTRL_WIDTH = 2;
    localparam int CTRL_RATIO = 4;
    localparam int CTRL_INIT = 6;
    localparam int CTRL_SPEED = 8;
    localparam int CTRL_CHAIN = 10;
    localparam int CTRL_INITEN = 11;
    localparam logic [1:0] MODE_PS = 2'h0;
    localparam logic [1:0] MODE_FPP = 2'h1;
    localparam logic [1:0] MODE_AS = 2'h2;
    localparam logic [1:0] INIT_OSC = 2'h0;
    localparam logic [1:0] INIT_USER = 2'h1;
    localparam logic [1:0] INIT_CFG = 2'h2;

    typedef enum logic [2:0] {
        ST_POR, ST_RESET, ST_RELEASE, ST_LOAD, ST_TAIL, ST_INIT, ST_USER
    } cls_state_type;
endpackage

// *** cls_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for pins from outside the core clock
module cls_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RESET_VAL;
            synced <= RESET_VAL;
        end else begin
            meta <= async;
            synced <= meta;
        end
    end
endmodule
`default_nettype wire

// *** tb_config_load_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module tb_config_load_sequencer;
    logic core_clk, rst_n, regWrite, regRead, reqN, stOut, stOe, statusN, done, hostClk, clkOut, clkOe;
    logic io0, io0Oe, selN, initN, initOe, userMode, userClk;
    logic [3:0] flashBus;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, cfgData;
    int errors, n_tests;
    // Open-drain status wire with pull-up; clock pin shared with device
    assign statusN = stOe ? stOut : 1'b1;
    cls_host_model host (.statusN(statusN), .requestN(reqN), .cfgClk(hostClk), .cfgData(cfgData));
    cls_config_load_sequencer #(.STATUS_MIN_CYCLES(17'd30), .INIT_OSC_CYCLES(17'd40),
        .INIT_CLOCK_CYCLES(17'd16)) dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .config_request_n(reqN), .cfg_state_n_in(statusN), .cfg_state_n_out(stOut), .cfg_state_n_oe(stOe),
        .load_complete(done), .cfg_clock_in(clkOe ? clkOut : hostClk), .cfg_clock_out(clkOut),
        .cfg_clock_oe(clkOe), .cfgData(cfgData), .flash_io0(io0), .flash_io0_oe(io0Oe),
        .flash_io_bus(flashBus), .flashSelect_n(selN), .user_init_clock(userClk), .initDone_n(initN),
        .initDoneOe(initOe), .userMode(userMode));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Free-running user clock, edges kept off the core clock's
    initial begin
        userClk = 1'b0;
        #7;
        forever #100 userClk = ~userClk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 chk(what, regRdata, exp);
    endtask
    // Request low must pull status and drop done quickly
    task automatic restart();
        fork
            host.reconfig();
            begin
                repeat (24) @(posedge core_clk);
                #1 chk("status pull", 32'(stOe), 32'h1);
                chk("done low", 32'(done), 32'h0);
                chk("user mode left", 32'(userMode), 32'h0);
            end
        join
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        errors++;
        conclude();
    end
    initial begin
        {regAddr, regWdata, regWrite, regRead, rst_n, errors, n_tests, flashBus} = '0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chk("por status", 32'(stOe), 32'h1);
        chk("por done", 32'(done), 32'h0);
        rdc(cls_pkg::ADDR_CTRL, 32'h0000_0000, "ctrl reset");
        rdc(cls_pkg::ADDR_LENGTH, 32'h0000_0000, "length reset");
        rdc(8'h14, 32'h0000_0000, "unmapped");
        $display("test reset finished");
        // Serial load, init on configuration clock
        wr(cls_pkg::ADDR_CTRL, 32'h0000_0080);
        wr(cls_pkg::ADDR_LENGTH, 32'h0000_0008);
        restart();
        host.send(7, 32'h0000_0052);
        repeat (4) @(posedge core_clk);
        chk("done early", 32'(done), 32'h0);
        host.send(1, 32'h0000_0001);
        repeat (4) @(posedge core_clk);
        chk("done set", 32'(done), 32'h1);
        rdc(cls_pkg::ADDR_DATA, 32'h0000_00A5, "data");
        rdc(cls_pkg::ADDR_COUNT, 32'h0000_0008, "count");
        host.pulses(20);
        repeat (5) @(posedge core_clk);
        chk("user mode", 32'(userMode), 32'h1);
        rdc(cls_pkg::ADDR_STATUS, 32'h0000_007E, "status");
        host.send(4, 32'h0000_000F);
        rdc(cls_pkg::ADDR_COUNT, 32'h0000_0008, "count frozen");
        $display("test serial load finished");
        // Oscillator init counts core cycles after the two falls
        wr(cls_pkg::ADDR_CTRL, 32'h0000_0000);
        wr(cls_pkg::ADDR_LENGTH, 32'h0000_0001);
        restart();
        host.send(1, 32'h0000_0001);
        host.pulses(2);
        repeat (20) @(posedge core_clk);
        chk("init early", 32'(userMode), 32'h0);
        repeat (30) @(posedge core_clk);
        chk("init end", 32'(userMode), 32'h1);
        $display("test oscillator init finished");
        // Parallel x16 at ratio four: one word per group of rises
        wr(cls_pkg::ADDR_CTRL, 32'h0000_0025);
        wr(cls_pkg::ADDR_LENGTH, 32'h0000_0003);
        restart();
        host.sendWords(3, 4, 32'h0001_1230);
        rdc(cls_pkg::ADDR_COUNT, 32'h0000_0003, "ratio count");
        rdc(cls_pkg::ADDR_DATA, 32'h0000_1232, "ratio data");
        $display("test parallel load finished");
        // Active serial x4, init on user clock, init-done pin enabled
        flashBus <= 4'h5;
        wr(cls_pkg::ADDR_CTRL, 32'h0000_0F46);
        wr(cls_pkg::ADDR_LENGTH, 32'h0000_0008);
        restart();
        rdc(cls_pkg::ADDR_STATUS, 32'h0000_0063, "as loading");
        chk("flash drive", 32'({selN, io0Oe, clkOe}), 32'h3);
        chk("init pin low", 32'({initN, initOe}), 32'h1);
        repeat (150) @(posedge core_clk);
        #1 chk("as done", 32'(done), 32'h1);
        chk("as user early", 32'(userMode), 32'h0);
        rdc(cls_pkg::ADDR_DATA, 32'h5555_5555, "as data");
        repeat (150) @(posedge core_clk);
        #1 chk("as user", 32'(userMode), 32'h1);
        chk("init pin off", 32'(initOe), 32'h0);
        $display("test active serial finished");
        conclude();
    end
endmodule
`default_nettype wire
